// ### mmd_pkg.sv
`default_nettype none
package mmd_pkg;
  // ==========================================================
  // memory blocks
  localparam int MMD_FLASH_BYTES = 65536;
  localparam int MMD_FLASH_HW_AW = 15;
  localparam int MMD_FLASH_KERNEL_HW = 1024;
  localparam logic [14:0] MMD_FLASH_KERNEL_BASE = 15'h7c00;
  localparam int MMD_FLASH_PAGE_LSB = 9;
  localparam int MMD_FLASH_PAGE_W = 7;
  localparam int MMD_SRAM_BYTES = 8192;
  localparam int MMD_SRAM_WORD_AW = 11;
  localparam logic [31:0] MMD_ALIAS_BASE = 32'h0000_0000;
  // ==========================================================
  // peripheral register space, top two 32 kB pages
  localparam logic [15:0] MMD_PRS_PREFIX = 16'hffff;
  localparam logic [31:0] MMD_BOOT_SEL_ADDR = 32'hffff_0220;
  localparam int MMD_BOOT_SEL_BIT = 0;
  localparam logic MMD_BOOT_SEL_RST = 1'b1;
  localparam int MMD_NREG = 19;
  // region limits as low halves of the address, end exclusive
  localparam logic [15:0] MMD_REG_BASE [MMD_NREG] = '{
    16'h0000, 16'h0220, 16'h0300, 16'h0320, 16'h0340, 16'h0360, 16'h0404, 16'h0440,
    16'h048c, 16'h0500, 16'h0600, 16'h0700, 16'h0800, 16'h0900, 16'h0a00, 16'h0b00,
    16'hf400, 16'hf800, 16'hfc00};
  localparam logic [15:0] MMD_REG_END [MMD_NREG] = '{
    16'h0110, 16'h0238, 16'h0310, 16'h0334, 16'h0350, 16'h0370, 16'h0420, 16'h0448,
    16'h0490, 16'h0538, 16'h0620, 16'h0730, 16'h0848, 16'h0948, 16'h0a14, 16'h0b54,
    16'hf46c, 16'hf820, 16'hfc3c};
  localparam int MMD_REG_SYSCTL = 1;
  localparam int MMD_REG_UART = 11;
  // ==========================================================
  // access sizes
  localparam logic [1:0] MMD_SZ_BYTE = 2'h0;
  localparam logic [1:0] MMD_SZ_HALF = 2'h1;
  localparam logic [1:0] MMD_SZ_WORD = 2'h2;
  typedef enum logic [2:0] {
    MMD_IDLE = 3'b000,
    MMD_SRAM = 3'b001,
    MMD_SRAM_RD = 3'b010,
    MMD_FLASH = 3'b011,
    MMD_PERI = 3'b100,
    MMD_RESP = 3'b101
  } mmd_state_t;
  typedef enum logic [2:0] {
    MMD_F_IDLE = 3'b000,
    MMD_F_LO = 3'b001,
    MMD_F_HI = 3'b010,
    MMD_F_DONE = 3'b011
  } mmd_fstate_t;
endpackage : mmd_pkg
`default_nettype wire

// ### mmd_flash_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mmd_flash_if;
  logic start;
  logic [15:0] addr;
  logic [1:0] size;
  logic done;
  logic [31:0] rdata;
  modport ctrl (output start, output addr, output size, input done, input rdata);
  modport unit (input start, input addr, input size, output done, output rdata);
endinterface : mmd_flash_if
`default_nettype wire

// ### mmd_flash_rd.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_flash_rd
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  mmd_flash_if.unit fif,
  output logic flash_rd,
  output logic [MMD_FLASH_HW_AW-1:0] flash_addr,
  input wire logic [15:0] flash_rdata
);
  mmd_fstate_t st_r;
  logic word_r;
  logic [15:0] lo_r;
  logic [31:0] rdata_r;

  assign fif.done = (st_r == MMD_F_DONE);
  assign fif.rdata = rdata_r;

  // ==========================================================
  // halfword sequencer, data taken in each strobe cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MMD_F_IDLE;
      word_r <= 1'b0;
      flash_rd <= 1'b0;
      flash_addr <= '0;
    end else begin
      flash_rd <= 1'b0;
      case (st_r)
        MMD_F_IDLE: begin
          if (fif.start) begin
            word_r <= (fif.size == MMD_SZ_WORD);
            flash_rd <= 1'b1;
            // word reads start at the low halfword of the word
            flash_addr <= (fif.size == MMD_SZ_WORD) ? {fif.addr[15:2], 1'b0} : fif.addr[15:1];
            st_r <= MMD_F_LO;
          end
        end
        MMD_F_LO: begin
          if (word_r) begin
            flash_rd <= 1'b1;
            flash_addr <= {flash_addr[MMD_FLASH_HW_AW-1:1], 1'b1};
            st_r <= MMD_F_HI;
          end else begin
            st_r <= MMD_F_DONE;
          end
        end
        MMD_F_HI: st_r <= MMD_F_DONE;
        MMD_F_DONE: st_r <= MMD_F_IDLE;
        default: st_r <= MMD_F_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_r <= '0;
      rdata_r <= '0;
    end else if (st_r == MMD_F_LO) begin
      lo_r <= flash_rdata;
      // a lone halfword is mirrored into both lanes
      rdata_r <= {flash_rdata, flash_rdata};
    end else if (st_r == MMD_F_HI) begin
      rdata_r <= {flash_rdata, lo_r};
    end
  end
endmodule : mmd_flash_rd
`default_nettype wire

// ### mmd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - flash aliased at zero after reset
// - cleared select bit puts sram at zero
// - little-endian byte lanes
// - 32k halfword flash, top 1k kernel
// - flash pages split on 512 bytes
// - word flash read is two halfwords
// - flash halfword per cycle, word per two
// - sram word in one access
// - flat 32-bit byte address space
// - peripherals decoded in top two pages
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter logic [31:0] FLASH_BASE = 32'h0008_0000,
  parameter logic [31:0] SRAM_BASE = 32'h0001_0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  output logic boot_alias_flash,
  output logic flash_rd,
  output logic [MMD_FLASH_HW_AW-1:0] flash_addr,
  input wire logic [15:0] flash_rdata,
  output logic [MMD_FLASH_PAGE_W-1:0] flash_page,
  output logic flash_kernel_area,
  output logic sram_en,
  output logic sram_we,
  output logic [3:0] sram_be,
  output logic [MMD_SRAM_WORD_AW-1:0] sram_addr,
  output logic [31:0] sram_wdata,
  input wire logic [31:0] sram_rdata,
  output logic [MMD_NREG-1:0] periph_sel,
  output logic periph_we,
  output logic [3:0] periph_be,
  output logic [15:0] periph_addr,
  output logic [31:0] periph_wdata,
  input wire logic [31:0] periph_rdata,
  input wire logic periph_ready
);
  mmd_flash_if fif ();
  mmd_state_t st_r;
  logic alias_flash_r;
  logic we_r;
  logic [1:0] size_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [3:0] be_r;
  logic [MMD_NREG-1:0] hit;
  logic in_flash, in_sram, in_alias, in_prs, is_boot_sel;
  logic [3:0] req_be;
  logic take;

  // ==========================================================
  // decode helpers
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
    case (size)
      MMD_SZ_BYTE: lane_mask = 4'h1 << a;
      MMD_SZ_HALF: lane_mask = a[1] ? 4'hc : 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  function automatic logic in_window(input logic [31:0] a, input logic [31:0] base, input int bytes);
    logic [31:0] d;
    d = a - base;
    in_window = (d < 32'(bytes));
  endfunction : in_window

  function automatic logic boot_sel_hit(input logic [31:0] a);
    boot_sel_hit = ({a[31:2], 2'b00} == MMD_BOOT_SEL_ADDR);
  endfunction : boot_sel_hit

  // ==========================================================
  // address decode
  // alias window shrinks to the sram size once sram sits at zero
  assign in_alias = in_window(cpu_addr, MMD_ALIAS_BASE, alias_flash_r ? MMD_FLASH_BYTES : MMD_SRAM_BYTES);
  assign in_flash = in_window(cpu_addr, FLASH_BASE, MMD_FLASH_BYTES) || (in_alias && alias_flash_r);
  assign in_sram = in_window(cpu_addr, SRAM_BASE, MMD_SRAM_BYTES) || (in_alias && !alias_flash_r);
  assign in_prs = (cpu_addr[31:16] == MMD_PRS_PREFIX);
  assign is_boot_sel = boot_sel_hit(cpu_addr);
  assign req_be = lane_mask(cpu_size, cpu_addr[1:0]);
  assign take = (st_r == MMD_IDLE) && cpu_req;

  genvar gi;
  generate
    for (gi = 0; gi < MMD_NREG; gi++) begin : g_region
      // only listed ranges select, gaps select nothing
      assign hit[gi] = in_prs && cpu_addr[15:0] >= MMD_REG_BASE[gi] && cpu_addr[15:0] < MMD_REG_END[gi];
    end
  endgenerate

  // ==========================================================
  // boot alias select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alias_flash_r <= MMD_BOOT_SEL_RST;
    end else if (take && cpu_we && is_boot_sel && req_be[MMD_BOOT_SEL_BIT]) begin
      // only a write that covers the select lane moves the alias
      alias_flash_r <= cpu_wdata[MMD_BOOT_SEL_BIT];
    end
  end
  assign boot_alias_flash = alias_flash_r;

  // ==========================================================
  // access sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MMD_IDLE;
      we_r <= 1'b0;
      size_r <= MMD_SZ_WORD;
      addr_r <= '0;
      wdata_r <= '0;
      be_r <= '0;
      periph_sel <= '0;
    end else begin
      case (st_r)
        MMD_IDLE: begin
          if (cpu_req) begin
            we_r <= cpu_we;
            size_r <= cpu_size;
            addr_r <= cpu_addr;
            wdata_r <= cpu_wdata;
            be_r <= req_be;
            if (in_sram) begin
              st_r <= MMD_SRAM;
            end else if (in_flash && !cpu_we) begin
              st_r <= MMD_FLASH;
            end else if (|hit) begin
              periph_sel <= hit;
              st_r <= MMD_PERI;
            end else begin
              // unmapped addresses and flash writes end at once, with no strobe
              st_r <= MMD_RESP;
            end
          end
        end
        // a write needs no data turn, so it ends one cycle before a read
        MMD_SRAM: st_r <= we_r ? MMD_RESP : MMD_SRAM_RD;
        MMD_SRAM_RD: st_r <= MMD_RESP;
        MMD_FLASH: begin
          // the flash unit paces itself; wait for its done pulse
          if (fif.done) begin
            st_r <= MMD_RESP;
          end
        end
        MMD_PERI: begin
          // select stays up until the peripheral answers
          if (periph_ready) begin
            periph_sel <= '0;
            st_r <= MMD_RESP;
          end
        end
        MMD_RESP: st_r <= MMD_IDLE;
        default: st_r <= MMD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= '0;
    end else if (take) begin
      // stale data must not look like the answer to a new access
      cpu_rdata <= '0;
    end else if (we_r) begin
      cpu_rdata <= cpu_rdata;
    end else if (st_r == MMD_SRAM_RD) begin
      cpu_rdata <= sram_rdata;
    end else if (st_r == MMD_FLASH && fif.done) begin
      cpu_rdata <= fif.rdata;
    end else if (st_r == MMD_PERI && periph_ready) begin
      // the select bit is answered here, not by the peripheral
      if (boot_sel_hit(addr_r)) begin
        cpu_rdata <= {31'h0, alias_flash_r};
      end else begin
        cpu_rdata <= periph_rdata;
      end
    end
  end
  // one-cycle ready pulse straight from the state register
  assign cpu_ready = (st_r == MMD_RESP);

  // ==========================================================
  // memory ports
  assign sram_en = (st_r == MMD_SRAM);
  assign sram_we = (st_r == MMD_SRAM) && we_r;
  assign sram_be = be_r;
  assign sram_addr = addr_r[MMD_SRAM_WORD_AW+1:2];
  assign sram_wdata = wdata_r;
  assign fif.start = (st_r == MMD_FLASH);
  assign fif.addr = addr_r[15:0];
  assign fif.size = size_r;
  assign flash_page = addr_r[MMD_FLASH_PAGE_LSB+MMD_FLASH_PAGE_W-1:MMD_FLASH_PAGE_LSB];
  assign flash_kernel_area = (addr_r[15:1] >= MMD_FLASH_KERNEL_BASE);
  assign periph_we = (st_r == MMD_PERI) && we_r;
  assign periph_be = be_r;
  assign periph_addr = addr_r[15:0];
  assign periph_wdata = wdata_r;

  mmd_flash_rd u_flash (
    .clk(clk),
    .resetn(resetn),
    .fif(fif),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .flash_rdata(flash_rdata)
  );
endmodule : mmd_decoder
`default_nettype wire

// ### mmd_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_decoder_sva
  import mmd_pkg::*;
#(
  parameter logic [31:0] SRAM_BASE = 32'h00010000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_ready,
  input wire logic [31:0] cpu_rdata,
  input wire logic boot_alias_flash,
  input wire logic flash_rd,
  input wire logic [14:0] flash_addr,
  input wire logic [6:0] flash_page,
  input wire logic flash_kernel_area,
  input wire logic sram_en,
  input wire logic [3:0] sram_be,
  input wire logic [10:0] sram_addr,
  input wire logic [18:0] periph_sel,
  input wire logic periph_we,
  input wire logic [3:0] periph_be,
  input wire logic [15:0] periph_addr,
  input wire logic periph_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic busy_r;
  // request taken while no access is open
  wire tk = cpu_req && !busy_r;
  wire srm = tk && cpu_addr[31:13] == SRAM_BASE[31:13];
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) busy_r <= 1'h0;
    else if (tk) busy_r <= 1'h1;
    else if (cpu_ready) busy_r <= 1'h0;
  boot_reset_a: assert property ($rose(resetn) |-> boot_alias_flash)
    else $error("flash not at zero");
  gap_ready_a: assert property (tk && cpu_addr[31:16] == 16'h0004 |=> cpu_ready && cpu_rdata == 32'h0
    && !sram_en && !flash_rd && periph_sel == 19'h0) else $error("gap access");
  sram_read_a: assert property (srm && !cpu_we |=> sram_en && sram_addr == cpu_addr[12:2] ##2 cpu_ready)
    else $error("sram read");
  sram_lane_a: assert property (srm && cpu_we && cpu_size == MMD_SZ_BYTE |=> sram_be == 4'h1 << cpu_addr[1:0])
    else $error("byte lane");
  alias_word_a: assert property (tk && !cpu_we && cpu_size == MMD_SZ_WORD && cpu_addr[31:16] == 16'h0 &&
    boot_alias_flash |=> ##[0:2] flash_rd && flash_addr == {cpu_addr[15:2], 1'h0} ##1 flash_rd && flash_addr[0])
    else $error("flash word fetch");
  flash_page_a: assert property (flash_rd |-> flash_page == flash_addr[14:8] &&
    flash_kernel_area == (flash_addr >= 15'h7c00)) else $error("flash page");
  uart_sel_a: assert property (tk && cpu_addr == 32'hffff0700 |=> periph_sel == 19'h00800)
    else $error("uart select");
  sel_write_a: assert property (tk && cpu_we && cpu_size == MMD_SZ_WORD && cpu_addr == 32'hffff0220 |=>
    periph_we && periph_sel == 19'h00002 && periph_be == 4'hf && periph_addr == 16'h0220) else $error("select write");
  sel_hold_a: assert property (periph_sel != 19'h0 && !periph_ready |=> $stable(periph_sel))
    else $error("select dropped");
  sel_done_a: assert property (periph_sel != 19'h0 && periph_ready |=> periph_sel == 19'h0 ##[0:1] cpu_ready)
    else $error("select end");
endmodule : mmd_decoder_sva
bind mmd_decoder mmd_decoder_sva #(.SRAM_BASE(SRAM_BASE)) chk (.clk, .resetn, .cpu_req, .cpu_we, .cpu_size,
  .cpu_addr, .cpu_ready, .cpu_rdata, .boot_alias_flash, .flash_rd, .flash_addr, .flash_page, .flash_kernel_area,
  .sram_en, .sram_be, .sram_addr, .periph_sel, .periph_we, .periph_be, .periph_addr, .periph_ready);
`default_nettype wire

// ### mmd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flash_rd,
  input wire logic [14:0] flash_addr,
  output logic [15:0] flash_rdata,
  input wire logic sram_en,
  input wire logic sram_we,
  input wire logic [3:0] sram_be,
  input wire logic [10:0] sram_addr,
  input wire logic [31:0] sram_wdata,
  output logic [31:0] sram_rdata,
  input wire logic [18:0] periph_sel,
  input wire logic [15:0] periph_addr,
  output logic [31:0] periph_rdata,
  output logic periph_ready
);
  logic [31:0] mem [2048];
  logic [1:0] wait_r;
  // data follows the strobed address in the same cycle, inverse when idle
  assign flash_rdata = flash_rd ? {flash_addr, 1'h1} : ~{flash_addr, 1'h1};
  always_ff @(posedge clk) begin
    sram_rdata <= sram_en && !sram_we ? mem[sram_addr] : ~sram_rdata;
    for (int i = 0; i < 4; i++)
      if (sram_en && sram_we && sram_be[i]) mem[sram_addr][8*i +: 8] <= sram_wdata[8*i +: 8];
  end
  // two wait cycles on each peripheral access
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) wait_r <= 2'h0;
    else wait_r <= periph_sel != 19'h0 && !periph_ready ? wait_r + 2'h1 : 2'h0;
  assign periph_ready = wait_r == 2'h2;
  assign periph_rdata = periph_ready ? {16'h5a5a, periph_addr} : ~{16'h5a5a, periph_addr};
endmodule : mmd_mem_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import mmd_pkg::*;
;
  typedef struct {logic we; logic [1:0] sz; logic [31:0] a, wd, rd; int lat;} mmd_row_t;
  logic clk, resetn, cpu_req, cpu_we, cpu_ready, boot_alias_flash, flash_rd, flash_kernel_area;
  logic sram_en, sram_we, periph_we, periph_ready;
  logic [1:0] cpu_size;
  logic [3:0] sram_be, periph_be;
  logic [6:0] flash_page;
  logic [10:0] sram_addr;
  logic [14:0] flash_addr;
  logic [15:0] flash_rdata, periph_addr;
  logic [18:0] periph_sel;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, sram_wdata, sram_rdata, periph_wdata, periph_rdata;
  int fail_count = 0;
  int tests_run = 0;
  // lat 0 leaves the cycle count unchecked
  mmd_row_t rows [11] = '{
    '{1'h1, 2'h2, 32'h00010010, 32'h44332211, 32'h0, 2},
    '{1'h1, 2'h0, 32'h00010012, 32'h00aa0000, 32'h0, 2},
    '{1'h0, 2'h2, 32'h00010010, 32'h0, 32'h44aa2211, 3},
    '{1'h0, 2'h2, 32'h00080404, 32'h0, 32'h04070405, 5},
    '{1'h0, 2'h1, 32'h00080006, 32'h0, 32'h00070007, 4},
    '{1'h0, 2'h2, 32'h0008f800, 32'h0, 32'hf803f801, 5},
    '{1'h1, 2'h2, 32'h00080000, 32'h1, 32'h0, 1},
    '{1'h0, 2'h2, 32'h00040000, 32'h0, 32'h0, 1},
    '{1'h0, 2'h2, 32'hffff0120, 32'h0, 32'h0, 1},
    '{1'h0, 2'h2, 32'hffff0700, 32'h0, 32'h5a5a0700, 4},
    '{1'h0, 2'h2, 32'h00000404, 32'h0, 32'h04070405, 5}};
  mmd_decoder dut (.clk, .resetn, .cpu_req, .cpu_we, .cpu_size, .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_rdata,
    .boot_alias_flash, .flash_rd, .flash_addr, .flash_rdata, .flash_page, .flash_kernel_area, .sram_en, .sram_we,
    .sram_be, .sram_addr, .sram_wdata, .sram_rdata, .periph_sel, .periph_we, .periph_be, .periph_addr,
    .periph_wdata, .periph_rdata, .periph_ready);
  mmd_mem_model far (.clk, .resetn, .flash_rd, .flash_addr, .flash_rdata, .sram_en, .sram_we, .sram_be,
    .sram_addr, .sram_wdata, .sram_rdata, .periph_sel, .periph_addr, .periph_rdata, .periph_ready);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // request held one cycle past the edge that samples ready
  task automatic run(input mmd_row_t r, input string nm);
    int n;
    n = 0;
    cpu_req = 1'h1;
    cpu_we = r.we;
    cpu_size = r.sz;
    cpu_addr = r.a;
    cpu_wdata = r.wd;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ready !== 1'h1 && n < 40);
    if (!r.we) chk32(nm, r.rd, cpu_rdata);
    if (r.lat > 0) chk32({nm, " cycles"}, 32'(r.lat), 32'(n));
    @(negedge clk);
    cpu_req = 1'h0;
    @(negedge clk);
    $display("%s done", nm);
  endtask : run
  initial begin
    resetn = 1'h0;
    cpu_req = 1'h0;
    cpu_we = 1'h0;
    cpu_size = 2'h0;
    cpu_addr = 32'h0;
    cpu_wdata = 32'h0;
    repeat (5) @(negedge clk);
    resetn = 1'h1;
    chk32("alias reset", 32'h1, 32'(boot_alias_flash));
    foreach (rows[i])
      run(rows[i], $sformatf("row%0d", i));
    run(mmd_row_t'{1'h1, 2'h2, MMD_BOOT_SEL_ADDR, 32'h0, 32'h0, 4}, "remap");
    chk32("alias remap", 32'h0, 32'(boot_alias_flash));
    run(mmd_row_t'{1'h0, 2'h2, 32'h00000010, 32'h0, 32'h44aa2211, 3}, "sram zero");
    resetn = 1'h0;
    @(negedge clk);
    resetn = 1'h1;
    chk32("alias rereset", 32'h1, 32'(boot_alias_flash));
    run(rows[10], "flash zero");
    tally_and_finish();
  end
  // fourteen accesses of at most ten cycles; 1000 cycles is ample
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
